// >>> src/reset_cause_status_logic.sv
`timescale 1ns/1ps
`include "reset_cause_defines.svh"

// Summary of operation
// - Distinguish eleven reset causes, including stack events
// - Power-on: PC zero, fixed flag pattern
// - Reset instruction: PC zero, clear its flag
// - Brown-out: PC zero, set three, clear brownout
// - Pin reset in run mode sets watchdog flag
// - Pin reset idle/sleep: set watchdog, clear powerdown
// - Pin reset at full power keeps stack flags
// - Watchdog reset when running clears watchdog flag
// - Stack full with enable resets, sets flag
// - Stack underflow with enable resets, sets flag
// - Underflow without enable only sets its flag
// - Watchdog in idle/sleep wakes at PC+2
// - Interrupt wake clears powerdown, continues PC+2
// - Enabled interrupt wake jumps to its vector
// - Unchanged flags hold; unimplemented bit reads zero

module reset_cause_status_logic (
  input  wire logic        CLOCK_I,
  input  wire logic        RST_N_I,
  input  wire logic [3:0]  ADDR_I,
  input  wire logic [7:0]  WDATA_I,
  input  wire logic        WR_I,
  input  wire logic        RD_I,
  output logic      [7:0]  RDATA_O,
  input  wire logic        BROWNOUT_I,
  input  wire logic        MASTER_CLEAR_I,
  input  wire logic        WATCHDOG_TIMEOUT_I,
  input  wire logic        RESET_INSTR_I,
  input  wire logic        STACK_FULL_I,
  input  wire logic        STACK_UNDERFLOW_I,
  input  wire logic        WAKE_INT_I,
  input  wire logic        WAKE_INT_HIGH_I,
  input  wire logic [1:0]  POWER_MODE_I,
  input  wire logic [20:0] CURRENT_PC_I,
  output logic             CORE_RESET_O,
  output logic             PC_LOAD_O,
  output logic      [20:0] PC_VALUE_O,
  output logic      [3:0]  CAUSE_CODE_O,
  output logic             IRQ_O
);

  reset_cause_pkg::power_mode_t            power_mode;
  reset_cause_pkg::cause_t                 cause_next;
  reset_cause_pkg::cause_t                 cause_reg;

  logic [`RC_FLAG_WIDTH-1:0]              flags_reg;
  logic [`RC_FLAG_WIDTH-1:0]              flags_next;
  logic [`RC_FLAG_WIDTH-1:0]              flags_base;
  logic [`RC_FLAG_WIDTH-1:0]              flag_set;
  logic [`RC_FLAG_WIDTH-1:0]              flag_clr;
  logic [`RC_CTRL_WIDTH-1:0]              ctrl_reg;
  logic [`RC_IRQ_WIDTH-1:0]               irq_mask_reg;
  logic [`RC_IRQ_WIDTH-1:0]               irq_status;
  logic [`RC_IRQ_WIDTH-1:0]               irq_event;
  logic [7:0]                             rdata_reg;
  logic [7:0]                             rdata_next;
  logic [`RC_PC_WIDTH-1:0]                pc_value_reg;
  logic [`RC_PC_WIDTH-1:0]                pc_target;
  logic [`RC_PC_WIDTH-1:0]                pc_after_wake;
  logic                                   pc_load_reg;
  logic                                   pc_load_next;
  logic                                   core_reset_reg;
  logic                                   core_reset_next;
  logic                                   stack_reset_en;
  logic                                   gie_high;
  logic                                   gie_low;
  logic                                   low_power;
  logic                                   wr_cause;
  logic                                   wr_ctrl;
  logic                                   wr_mask;
  logic                                   rd_status;

  assign power_mode     = reset_cause_pkg::power_mode_t'(POWER_MODE_I);
  assign stack_reset_en = ctrl_reg[`RC_CTRL_STACK_RST];
  assign gie_high       = ctrl_reg[`RC_CTRL_GIE_HIGH];
  assign gie_low        = ctrl_reg[`RC_CTRL_GIE_LOW];
  assign low_power      = (power_mode == reset_cause_pkg::PM_IDLE) ||
                          (power_mode == reset_cause_pkg::PM_SLEEP);

  assign wr_cause  = WR_I && (ADDR_I == `RC_ADDR_CAUSE);
  assign wr_ctrl   = WR_I && (ADDR_I == `RC_ADDR_CTRL);
  assign wr_mask   = WR_I && (ADDR_I == `RC_ADDR_IRQ_MASK);
  assign rd_status = RD_I && (ADDR_I == `RC_ADDR_IRQ_STATUS);

  // Several events in one cycle: the most severe one decides alone
  always_comb
  begin
    cause_next = reset_cause_pkg::CAUSE_NONE;
    if (BROWNOUT_I)
      cause_next = reset_cause_pkg::CAUSE_BROWNOUT;
    else if (MASTER_CLEAR_I)
    begin
      if (low_power)
        cause_next = reset_cause_pkg::CAUSE_MASTER_CLEAR_PIN_SLEEP;
      else if (power_mode == reset_cause_pkg::PM_RUN)
        cause_next = reset_cause_pkg::CAUSE_MASTER_CLEAR_PIN_RUN;
      else
        cause_next = reset_cause_pkg::CAUSE_MASTER_CLEAR_PIN_FULL;
    end
    else if (WATCHDOG_TIMEOUT_I)
    begin
      if (low_power)
        cause_next = reset_cause_pkg::CAUSE_WDT_WAKE;
      else
        cause_next = reset_cause_pkg::CAUSE_WDT_RESET;
    end
    else if (STACK_FULL_I && stack_reset_en)
      cause_next = reset_cause_pkg::CAUSE_STACK_FULL;
    else if (STACK_UNDERFLOW_I)
    begin
      if (stack_reset_en)
        cause_next = reset_cause_pkg::CAUSE_STACK_UNF;
      else
        cause_next = reset_cause_pkg::CAUSE_UNF_ERROR;
    end
    else if (RESET_INSTR_I)
      cause_next = reset_cause_pkg::CAUSE_RESET_INS;
    else if (WAKE_INT_I && (power_mode != reset_cause_pkg::PM_FULL))
      cause_next = reset_cause_pkg::CAUSE_INT_WAKE;
  end

  // Per-event flag edits; every bit not named here holds its value
  always_comb
  begin
    flag_set = '0;
    flag_clr = '0;
    case (cause_next)
      reset_cause_pkg::CAUSE_BROWNOUT:
      begin
        flag_set[`RC_BIT_RESET_INSTR] = 1'b1;
        flag_set[`RC_BIT_WDT_EXPIRED] = 1'b1;
        flag_set[`RC_BIT_POWERDOWN]   = 1'b1;
        flag_clr[`RC_BIT_BROWNOUT]    = 1'b1;
      end
      reset_cause_pkg::CAUSE_MASTER_CLEAR_PIN_FULL:
      begin
        flag_set[`RC_BIT_WDT_EXPIRED] = 1'b1;
      end
      reset_cause_pkg::CAUSE_MASTER_CLEAR_PIN_RUN:
      begin
        flag_set[`RC_BIT_WDT_EXPIRED] = 1'b1;
      end
      reset_cause_pkg::CAUSE_MASTER_CLEAR_PIN_SLEEP:
      begin
        flag_set[`RC_BIT_WDT_EXPIRED] = 1'b1;
        flag_clr[`RC_BIT_POWERDOWN]   = 1'b1;
      end
      reset_cause_pkg::CAUSE_WDT_RESET:
      begin
        flag_clr[`RC_BIT_WDT_EXPIRED] = 1'b1;
      end
      reset_cause_pkg::CAUSE_WDT_WAKE:
      begin
        flag_clr[`RC_BIT_WDT_EXPIRED] = 1'b1;
        flag_clr[`RC_BIT_POWERDOWN]   = 1'b1;
      end
      reset_cause_pkg::CAUSE_STACK_FULL:
      begin
        flag_set[`RC_BIT_STACK_FULL] = 1'b1;
      end
      reset_cause_pkg::CAUSE_STACK_UNF:
      begin
        flag_set[`RC_BIT_STACK_UNF] = 1'b1;
      end
      reset_cause_pkg::CAUSE_UNF_ERROR:
      begin
        flag_set[`RC_BIT_STACK_UNF] = 1'b1;
      end
      reset_cause_pkg::CAUSE_RESET_INS:
      begin
        flag_clr[`RC_BIT_RESET_INSTR] = 1'b1;
      end
      reset_cause_pkg::CAUSE_INT_WAKE:
      begin
        flag_clr[`RC_BIT_POWERDOWN] = 1'b1;
      end
      default:
      begin
        flag_set = '0;
        flag_clr = '0;
      end
    endcase
  end

  // A software write lands first; hardware edits on the same bits win
  assign flags_base = wr_cause ? WDATA_I[`RC_FLAG_WIDTH-1:0] : flags_reg;
  assign flags_next = (flags_base & ~flag_clr) | flag_set;

  assign pc_after_wake = CURRENT_PC_I + `RC_PC_STEP;

  // Where execution resumes, and whether the core is held in reset
  always_comb
  begin
    pc_target       = `RC_PC_RESET;
    pc_load_next    = 1'b1;
    core_reset_next = 1'b1;
    case (cause_next)
      reset_cause_pkg::CAUSE_BROWNOUT,
      reset_cause_pkg::CAUSE_MASTER_CLEAR_PIN_FULL,
      reset_cause_pkg::CAUSE_MASTER_CLEAR_PIN_RUN,
      reset_cause_pkg::CAUSE_MASTER_CLEAR_PIN_SLEEP,
      reset_cause_pkg::CAUSE_WDT_RESET,
      reset_cause_pkg::CAUSE_STACK_FULL,
      reset_cause_pkg::CAUSE_STACK_UNF,
      reset_cause_pkg::CAUSE_RESET_INS:
      begin
        pc_target = `RC_PC_RESET;
      end
      reset_cause_pkg::CAUSE_WDT_WAKE:
      begin
        core_reset_next = 1'b0;
        pc_target       = pc_after_wake;
      end
      reset_cause_pkg::CAUSE_INT_WAKE:
      begin
        core_reset_next = 1'b0;
        if (WAKE_INT_HIGH_I && gie_high)
          pc_target = `RC_VEC_HIGH;
        else if (!WAKE_INT_HIGH_I && gie_low)
          pc_target = `RC_VEC_LOW;
        else
          pc_target = pc_after_wake;
      end
      default:
      begin
        // Covers the underflow error too: no reset, no jump
        pc_load_next    = 1'b0;
        core_reset_next = 1'b0;
      end
    endcase
  end

  // Reset cause flags; the power-on pattern comes from the RST_N_I reset
  always_ff @(posedge CLOCK_I)
  begin
    if (!RST_N_I)
      flags_reg <= `RC_CAUSE_POR_VAL;
    else
      flags_reg <= flags_next;
  end

  // Control register steers stack resets and wake vectors
  always_ff @(posedge CLOCK_I)
  begin
    if (!RST_N_I)
      ctrl_reg <= `RC_CTRL_RST_VAL;
    else if (wr_ctrl)
      ctrl_reg <= WDATA_I[`RC_CTRL_WIDTH-1:0];
  end

  always_ff @(posedge CLOCK_I)
  begin
    if (!RST_N_I)
      irq_mask_reg <= `RC_MASK_RST_VAL;
    else if (wr_mask)
      irq_mask_reg <= WDATA_I;
  end

  // Program counter handoff; power-on also loads zero once
  always_ff @(posedge CLOCK_I)
  begin
    if (!RST_N_I)
    begin
      pc_value_reg   <= `RC_PC_RESET;
      pc_load_reg    <= 1'b1;
      core_reset_reg <= 1'b1;
    end
    else
    begin
      pc_load_reg    <= pc_load_next;
      core_reset_reg <= core_reset_next;
      if (pc_load_next)
        pc_value_reg <= pc_target;
    end
  end

  always_ff @(posedge CLOCK_I)
  begin
    if (!RST_N_I)
      cause_reg <= reset_cause_pkg::CAUSE_NONE;
    else if (cause_next != reset_cause_pkg::CAUSE_NONE)
      cause_reg <= cause_next;
  end

  // Event strobes feeding the sticky interrupt status
  always_comb
  begin
    irq_event = '0;
    irq_event[`RC_IRQ_BROWNOUT] = (cause_next == reset_cause_pkg::CAUSE_BROWNOUT);
    irq_event[`RC_IRQ_MASTER_CLEAR_PIN]     = (cause_next == reset_cause_pkg::CAUSE_MASTER_CLEAR_PIN_FULL) ||
                                  (cause_next == reset_cause_pkg::CAUSE_MASTER_CLEAR_PIN_RUN) ||
                                  (cause_next == reset_cause_pkg::CAUSE_MASTER_CLEAR_PIN_SLEEP);
    irq_event[`RC_IRQ_WDT_RESET]   = (cause_next == reset_cause_pkg::CAUSE_WDT_RESET);
    irq_event[`RC_IRQ_WDT_WAKE]    = (cause_next == reset_cause_pkg::CAUSE_WDT_WAKE);
    irq_event[`RC_IRQ_STACK_FULL]  = (cause_next == reset_cause_pkg::CAUSE_STACK_FULL);
    irq_event[`RC_IRQ_STACK_UNF]   = (cause_next == reset_cause_pkg::CAUSE_STACK_UNF) ||
                                     (cause_next == reset_cause_pkg::CAUSE_UNF_ERROR);
    irq_event[`RC_IRQ_RESET_INSTR] = (cause_next == reset_cause_pkg::CAUSE_RESET_INS);
    irq_event[`RC_IRQ_INT_WAKE]    = (cause_next == reset_cause_pkg::CAUSE_INT_WAKE);
  end

  genvar gi;
  generate
    for (gi = 0; gi < `RC_IRQ_WIDTH; gi = gi + 1)
    begin : g_irq
      sticky_status_bit #(
        .RESET_VAL (1'b0)
      ) u_status (
        .clk_i   (CLOCK_I),
        .rst_n_i (RST_N_I),
        .set_i   (irq_event[gi]),
        .clear_i (rd_status),
        .flag_o  (irq_status[gi])
      );
    end
  endgenerate

  // Read data is the pre-clear value, so no event is lost to the read
  always_comb
  begin
    rdata_next = 8'h00;
    if (RD_I)
    begin
      case (ADDR_I)
        `RC_ADDR_CAUSE:      rdata_next = {1'b0, flags_reg};
        `RC_ADDR_CTRL:       rdata_next = {5'h00, ctrl_reg};
        `RC_ADDR_IRQ_STATUS: rdata_next = irq_status;
        `RC_ADDR_IRQ_MASK:   rdata_next = irq_mask_reg;
        default:             rdata_next = 8'h00;
      endcase
    end
  end

  // Data holds only in the cycle after the read strobe
  always_ff @(posedge CLOCK_I)
  begin
    if (!RST_N_I)
      rdata_reg <= 8'h00;
    else
      rdata_reg <= rdata_next;
  end

  assign RDATA_O      = rdata_reg;
  assign CORE_RESET_O = core_reset_reg;
  assign PC_LOAD_O    = pc_load_reg;
  assign PC_VALUE_O   = pc_value_reg;
  assign CAUSE_CODE_O = cause_reg;
  assign IRQ_O        = |(irq_status & irq_mask_reg);

endmodule : reset_cause_status_logic

// >>> src/reset_cause_defines.svh
`ifndef RESET_CAUSE_DEFINES_SVH
`define RESET_CAUSE_DEFINES_SVH

// Register offsets on the plain register port
`define RC_ADDR_CAUSE      4'h0
`define RC_ADDR_CTRL       4'h1
`define RC_ADDR_IRQ_STATUS 4'h2
`define RC_ADDR_IRQ_MASK   4'h3

// Reset cause register field positions
`define RC_BIT_BROWNOUT    0
`define RC_BIT_POWER_ON    1
`define RC_BIT_POWERDOWN   2
`define RC_BIT_WDT_EXPIRED 3
`define RC_BIT_RESET_INSTR 4
`define RC_BIT_STACK_UNF   5
`define RC_BIT_STACK_FULL  6
`define RC_FLAG_WIDTH      7

// Control register field positions
`define RC_CTRL_STACK_RST  0
`define RC_CTRL_GIE_HIGH   1
`define RC_CTRL_GIE_LOW    2
`define RC_CTRL_WIDTH      3

// Interrupt status bit positions
`define RC_IRQ_BROWNOUT    0
`define RC_IRQ_MASTER_CLEAR_PIN        1
`define RC_IRQ_WDT_RESET   2
`define RC_IRQ_WDT_WAKE    3
`define RC_IRQ_STACK_FULL  4
`define RC_IRQ_STACK_UNF   5
`define RC_IRQ_RESET_INSTR 6
`define RC_IRQ_INT_WAKE    7
`define RC_IRQ_WIDTH       8

// Reset values
`define RC_CAUSE_POR_VAL   7'h1c
`define RC_CTRL_RST_VAL    3'h1
`define RC_MASK_RST_VAL    8'h00

// Program counter targets
`define RC_PC_WIDTH        21
`define RC_PC_RESET        21'h000000
`define RC_PC_STEP         21'h000002
`define RC_VEC_HIGH        21'h000008
`define RC_VEC_LOW         21'h000018

`endif

// >>> src/reset_cause_pkg.sv
package reset_cause_pkg;

  typedef enum logic [1:0]
  {
    PM_FULL  = 2'b00,
    PM_RUN   = 2'b01,
    PM_IDLE  = 2'b10,
    PM_SLEEP = 2'b11
  } power_mode_t;

  typedef enum logic [3:0]
  {
    CAUSE_NONE       = 4'b0000,
    CAUSE_BROWNOUT   = 4'b0001,
    CAUSE_MASTER_CLEAR_PIN_FULL  = 4'b0010,
    CAUSE_MASTER_CLEAR_PIN_RUN   = 4'b0011,
    CAUSE_MASTER_CLEAR_PIN_SLEEP = 4'b0100,
    CAUSE_WDT_RESET  = 4'b0101,
    CAUSE_WDT_WAKE   = 4'b0110,
    CAUSE_STACK_FULL = 4'b0111,
    CAUSE_STACK_UNF  = 4'b1000,
    CAUSE_UNF_ERROR  = 4'b1001,
    CAUSE_RESET_INS  = 4'b1010,
    CAUSE_INT_WAKE   = 4'b1011
  } cause_t;

endpackage : reset_cause_pkg

// >>> src/sticky_status_bit.sv
`timescale 1ns/1ps

module sticky_status_bit #(
  parameter logic RESET_VAL = 1'b0
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic set_i,
  input  wire logic clear_i,
  output logic      flag_o
);

  logic flag_reg;

  // Set beats clear so an event in the clearing cycle survives
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      flag_reg <= RESET_VAL;
    else if (set_i)
      flag_reg <= 1'b1;
    else if (clear_i)
      flag_reg <= 1'b0;
  end

  assign flag_o = flag_reg;

endmodule : sticky_status_bit

// >>> tb/reset_cause_status_logic_asserts.sv
`timescale 1ns/1ps

module reset_cause_checker (
  input wire logic        CLOCK_I,
  input wire logic        RST_N_I,
  input wire logic [3:0]  ADDR_I,
  input wire logic        RD_I,
  input wire logic [7:0]  RDATA_O,
  input wire logic        BROWNOUT_I,
  input wire logic        MASTER_CLEAR_I,
  input wire logic        WATCHDOG_TIMEOUT_I,
  input wire logic        RESET_INSTR_I,
  input wire logic        STACK_FULL_I,
  input wire logic        STACK_UNDERFLOW_I,
  input wire logic        WAKE_INT_I,
  input wire logic [1:0]  POWER_MODE_I,
  input wire logic [20:0] CURRENT_PC_I,
  input wire logic        CORE_RESET_O,
  input wire logic        PC_LOAD_O,
  input wire logic [20:0] PC_VALUE_O,
  input wire logic [3:0]  CAUSE_CODE_O
);
  // Events by priority, lowest index wins
  logic [6:0] ev_vec;
  assign ev_vec = {WAKE_INT_I, RESET_INSTR_I, STACK_UNDERFLOW_I, STACK_FULL_I,
                   WATCHDOG_TIMEOUT_I, MASTER_CLEAR_I, BROWNOUT_I};
  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (!RST_N_I);

  a_quiet_no_reset: assert property (RST_N_I && ev_vec == 7'h00 |=> !CORE_RESET_O && !PC_LOAD_O)
    else $error("reset or load without an event");
  a_brownout_reset: assert property (BROWNOUT_I |=> CORE_RESET_O && PC_VALUE_O == 21'h000000 && CAUSE_CODE_O == 4'h1)
    else $error("brownout did not reset to zero");
  a_pin_reset: assert property (ev_vec[1:0] == 2'b10 |=> CORE_RESET_O && PC_LOAD_O && PC_VALUE_O == 21'h000000)
    else $error("pin reset did not reset to zero");
  a_wdog_reset: assert property (ev_vec[2:0] == 3'b100 && !POWER_MODE_I[1] |=> CORE_RESET_O && PC_VALUE_O == 21'h0)
    else $error("watchdog expiry while running did not reset");
  a_wdog_wake: assert property (ev_vec[2:0] == 3'b100 && POWER_MODE_I[1] |=>
    !CORE_RESET_O && PC_LOAD_O && PC_VALUE_O == $past(CURRENT_PC_I) + 21'h000002)
    else $error("watchdog wake did not continue at next instruction");
  a_stack_full: assert property (ev_vec[3:0] == 4'h8 |=> CORE_RESET_O == PC_LOAD_O &&
    (!CORE_RESET_O || (PC_VALUE_O == 21'h0 && CAUSE_CODE_O == 4'h7)))
    else $error("stack full handled wrongly");
  a_underflow_kind: assert property (ev_vec[4:0] == 5'h10 |=>
    PC_LOAD_O == CORE_RESET_O && CAUSE_CODE_O == (CORE_RESET_O ? 4'h8 : 4'h9))
    else $error("underflow reset and error mixed up");
  a_instr_reset: assert property (ev_vec[5:0] == 6'h20 |=> CORE_RESET_O && PC_VALUE_O == 21'h0 && CAUSE_CODE_O == 4'ha)
    else $error("reset instruction did not reset to zero");
  a_wake_target: assert property (ev_vec == 7'h40 && POWER_MODE_I != 2'b00 |=> !CORE_RESET_O && PC_LOAD_O &&
    (PC_VALUE_O == 21'h000008 || PC_VALUE_O == 21'h000018 || PC_VALUE_O == $past(CURRENT_PC_I) + 21'h000002))
    else $error("interrupt wake target wrong");
  a_top_bit_zero: assert property (RD_I && ADDR_I == 4'h0 |=> !RDATA_O[7])
    else $error("unused cause bit read as one");
endmodule : reset_cause_checker

bind reset_cause_status_logic reset_cause_checker u_chk (.*);

// >>> tb/reset_cause_status_logic_tb_top.sv
`timescale 1ns/1ps

module reset_cause_status_logic_tb_top;
  logic        clk = 1'b0;
  logic        rst_n, wr, rd, wake_hi, core_rst, pc_load, irq;
  logic [3:0]  addr, cause, mcause;
  logic [7:0]  wdata, rdata, mstat, mmask;
  logic [6:0]  ev, mf;
  logic [2:0]  mctrl;
  logic [1:0]  mode;
  logic [20:0] pc_in, pc_out, mpc;
  int          miscompares, n_compared, cyc;

  reset_cause_status_logic u_dut (
    .CLOCK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
    .BROWNOUT_I(ev[0]), .MASTER_CLEAR_I(ev[1]), .WATCHDOG_TIMEOUT_I(ev[2]), .STACK_FULL_I(ev[3]),
    .STACK_UNDERFLOW_I(ev[4]), .RESET_INSTR_I(ev[5]), .WAKE_INT_I(ev[6]), .WAKE_INT_HIGH_I(wake_hi),
    .POWER_MODE_I(mode), .CURRENT_PC_I(pc_in), .CORE_RESET_O(core_rst), .PC_LOAD_O(pc_load),
    .PC_VALUE_O(pc_out), .CAUSE_CODE_O(cause), .IRQ_O(irq)
  );

  always #4 clk = ~clk;

  task wrap_up;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : wrap_up

  // A hung bench still reaches the verdict
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      miscompares++;
      wrap_up();
    end
  end

  task cmp_reg(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp_reg

  task cmp_pc(input logic [20:0] got, input logic [20:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR t=%0t pc got %h exp %h", $time, got, exp);
    end
  endtask : cmp_pc

  task wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    if (a == 4'h0) mf = d[6:0];
    if (a == 4'h1) mctrl = d[2:0];
    if (a == 4'h3) mmask = d;
  endtask : wr_reg

  task rd_chk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    cmp_reg(rdata, exp);
    if (a == 4'h2) mstat = 8'h00;
    // Read data must fall back to zero once its cycle is over
    @(posedge clk);
    #1;
    cmp_reg(rdata, 8'h00);
  endtask : rd_chk

  task fire(input int k, input logic [1:0] m_in);
    logic [1:0] m;
    logic       rs, ld;
    int         sb;
    // Wake in full power is ignored, so keep it in a managed mode
    m = (k == 6 && m_in == 2'b00) ? 2'b01 : m_in;
    @(posedge clk);
    ev      <= 7'h01 << k;
    mode    <= m;
    pc_in   <= 21'($urandom);
    wake_hi <= 1'($urandom);
    @(posedge clk);
    ev <= 7'h00;
    ld = !((k == 3 || k == 4) && !mctrl[0]);
    rs = ld && !(k == 2 && m[1]) && k != 6;
    sb = (k < 2) ? k : (k == 2) ? (m[1] ? 3 : 2) : k + 1;
    case (k)
      0: mf = {mf[6:5], 3'b111, mf[1], 1'b0};
      1: mf = {mf[6:4], 1'b1, mf[2] & ~m[1], mf[1:0]};
      2: mf = {mf[6:4], 1'b0, mf[2] & ~m[1], mf[1:0]};
      3: mf[6] = mf[6] | mctrl[0];
      4: mf[5] = 1'b1;
      5: mf[4] = 1'b0;
      default: mf[2] = 1'b0;
    endcase
    case (k)
      0: mcause = 4'h1;
      1: mcause = (m == 2'b00) ? 4'h2 : (m == 2'b01) ? 4'h3 : 4'h4;
      2: mcause = m[1] ? 4'h6 : 4'h5;
      3: mcause = mctrl[0] ? 4'h7 : mcause;
      4: mcause = mctrl[0] ? 4'h8 : 4'h9;
      5: mcause = 4'ha;
      default: mcause = 4'hb;
    endcase
    if (rs) mpc = 21'h000000;
    else if (k == 6 && wake_hi && mctrl[1]) mpc = 21'h000008;
    else if (k == 6 && !wake_hi && mctrl[2]) mpc = 21'h000018;
    else if (k == 2 || k == 6) mpc = pc_in + 21'h000002;
    if (!(k == 3 && !mctrl[0])) mstat[sb] = 1'b1;
    #1;
    cmp_reg({7'h00, core_rst}, {7'h00, rs});
    cmp_reg({7'h00, pc_load}, {7'h00, ld});
    cmp_pc(pc_out, mpc);
    cmp_reg({4'h0, cause}, {4'h0, mcause});
    cmp_reg({7'h00, irq}, {7'h00, |(mstat & mmask)});
    rd_chk(4'h0, {1'b0, mf});
  endtask : fire

  initial
  begin
    {ev, mode, pc_in, wake_hi, addr, wdata, wr, rd, rst_n} = '0;
    {mf, mctrl, mstat, mmask, mpc, mcause} = {7'h1c, 3'h1, 8'h00, 8'h00, 21'h0, 4'h0};
    void'($urandom(54344));
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(4'h0, 8'h1c);
    rd_chk(4'h1, 8'h01);
    rd_chk(4'h2, 8'h00);
    rd_chk(4'h3, 8'h00);
    rd_chk(4'h9, 8'h00);
    cmp_pc(pc_out, 21'h000000);
    wr_reg(4'h0, 8'hff);
    rd_chk(4'h0, 8'h7f);
    wr_reg(4'h0, 8'h03);
    $display("test reset_values done");
    wr_reg(4'h3, 8'hff);
    for (int k = 0; k < 7; k++)
      for (int m = 0; m < 4; m++)
        fire(k, 2'(m));
    // Wake at full power is not a wake: nothing may move
    @(posedge clk);
    ev   <= 7'h40;
    mode <= 2'b00;
    @(posedge clk);
    ev <= 7'h00;
    #1;
    cmp_reg({6'h00, core_rst, pc_load}, 8'h00);
    cmp_reg({4'h0, cause}, {4'h0, mcause});
    rd_chk(4'h0, {1'b0, mf});
    rd_chk(4'h2, mstat);
    $display("test all_events done");
    // Random enables and masks reach the stack and vector paths
    for (int i = 0; i < 60; i++)
    begin
      wr_reg(4'h1, 8'($urandom));
      wr_reg(4'h3, 8'($urandom));
      rd_chk(4'h1, {5'h00, mctrl});
      fire($urandom % 7, 2'($urandom));
      if (i % 3 == 0) rd_chk(4'h2, mstat);
      cmp_reg({7'h00, irq}, {7'h00, |(mstat & mmask)});
    end
    $display("test random_events done");
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    {mf, mctrl, mstat, mmask} = {7'h1c, 3'h1, 8'h00, 8'h00};
    mpc    = 21'h000000;
    mcause = 4'h0;
    rd_chk(4'h0, 8'h1c);
    rd_chk(4'h1, 8'h01);
    cmp_pc(pc_out, mpc);
    cmp_reg({cause, core_rst, pc_load, irq, 1'b0}, {mcause, 4'h0});
    $display("test second_reset done");
    wrap_up();
  end
endmodule : reset_cause_status_logic_tb_top
